// File: rtl/ief_defines.svh
// Constants for the interrupt enable and error flag block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef IEF_DEFINES_SVH
`define IEF_DEFINES_SVH
`define IEF_ADDR_W          8
`define IEF_ADDR_IRQ_EN     8'h09
`define IEF_ADDR_ERROR      8'h0A
`define IEF_ADDR_CTRL       8'h0E
`define IEF_IRQ_EN_RST      8'h00
`define IEF_CTRL_RST        8'h00
`define IEF_BIT_PUSH_PULL   7
`define IEF_BIT_PIN_GATE    6
`define IEF_BIT_CARD_EN     5
`define IEF_BIT_EE          7
`define IEF_BIT_WR_MISUSE   6
`define IEF_BIT_OVERFLOW    5
`define IEF_BIT_SHORT       4
`define IEF_BIT_EMPTY       3
`define IEF_BIT_COLL        2
`define IEF_BIT_PROT        1
`define IEF_BIT_INTEG       0
`define IEF_CTRL_INVERT     0
`define IEF_CTRL_COLL_INTEG 1
`define IEF_CTRL_MULTI      2
`define IEF_CTRL_SUPPRESS   3
`define IEF_MIN_BITS        4
`define IEF_MIN_BYTES       3
`endif

// File: rtl/ief_pkg.sv
// Types for the interrupt enable and error flag block.
// Assumes the receive state codes match the host-visible state field.
package ief_pkg;
   typedef enum logic [2:0]
   {
      IEF_CS_IDLE    = 3'h0,
      IEF_CS_TXWAIT  = 3'h1,
      IEF_CS_TX      = 3'h3,
      IEF_CS_RECEIVE_WAIT_STATE  = 3'h5,
      IEF_CS_WAITDAT = 3'h6,
      IEF_CS_RX      = 3'h7
   } ief_com_state_t;
endpackage : ief_pkg

// File: rtl/ief_irq_error.sv
// Interrupt enable gating, interrupt pin drive and contactless error flags.
// Assumes all event inputs are one-cycle pulses from logic on sys_clk.
`include "ief_defines.svh"
module ief_irq_error
   import ief_pkg::*;
#(
   parameter int NUM_TIMERS = 5
)
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic [`IEF_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [7:0]             reg_rdata,
   input  wire logic [NUM_TIMERS-1:0]  timer_underflow_request,
   input  wire logic                   card_detect_request,
   input  wire logic [2:0]             com_state,
   input  wire logic                   crc_may_send,
   input  wire logic                   auth_active,
   input  wire logic                   cmd_start,
   input  wire logic                   receive_start,
   input  wire logic                   transceive_cmd,
   input  wire logic                   errors_appended,
   input  wire logic                   eeprom_cmd_done,
   input  wire logic                   eeprom_cmd_fail,
   input  wire logic                   fifo_wr,
   input  wire logic                   fifo_full,
   input  wire logic                   send_needed,
   input  wire logic                   fifo_empty,
   input  wire logic                   frame_end,
   input  wire logic                   sof_valid,
   input  wire logic [15:0]            frame_bits,
   input  wire logic                   collision,
   input  wire logic                   collision_in_eof,
   input  wire logic [6:0]             collision_pos,
   input  wire logic                   stop_bit_bad,
   input  wire logic                   sof_eof_bad,
   input  wire logic                   byte_count_bad,
   input  wire logic                   byte_ready,
   input  wire logic                   parity_bad,
   input  wire logic                   crc_bad,
   output logic                        fifo_wr_accept,
   output logic                        rx_byte_store,
   output logic                        rx_stop,
   output logic                        frame_drop,
   output logic                        receive_done_request,
   output logic                        error_request_flag,
   output logic                        combined_interrupt_flag,
   output logic [7:0]                  collision_position_register,
   output logic                        irq_pin_out,
   output logic                        irq_pin_oe
);
   // Enable register holds exactly five timer gates below bit 5
   if (NUM_TIMERS != 5)
   begin : g_bad_timers
      $error("NUM_TIMERS must be 5 to fit the enable register");
   end

   logic [7:0] irq_en_reg, irq_en_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] err_reg, err_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [7:0] coll_pos_reg, coll_pos_next;
   logic       comb_reg, comb_next;
   logic       erq_reg, erq_next;
   logic       pin_reg, pin_next, oe_reg, oe_next;
   logic       acc_reg, acc_next, store_reg, store_next;
   logic       stop_reg, stop_next, drop_reg, drop_next;
   logic       rxdone_reg, rxdone_next;
   logic       busy_wr, short_frame, rx_clear, coll_hit, prot_hit;
   logic       integ_hit, active;

   // Event decoding from the surrounding receive and FIFO logic
   always_comb
   begin
      busy_wr = fifo_wr && (crc_may_send || auth_active
                || com_state == IEF_CS_RECEIVE_WAIT_STATE
                || com_state == IEF_CS_WAITDAT
                || com_state == IEF_CS_RX);
      short_frame = frame_end && sof_valid &&
         ((frame_bits < 16'(`IEF_MIN_BITS)) ||
          (ctrl_reg[`IEF_CTRL_SUPPRESS] &&
           frame_bits < 16'(`IEF_MIN_BYTES * 8)));
      rx_clear = (receive_start && !transceive_cmd) ||
         (transceive_cmd && com_state == IEF_CS_WAITDAT);
      coll_hit = collision && !collision_in_eof;
      prot_hit = stop_bit_bad || sof_eof_bad || byte_count_bad;
      integ_hit = parity_bad || crc_bad ||
         (coll_hit && ctrl_reg[`IEF_CTRL_COLL_INTEG]);
   end

   // Register writes; error register is not writable
   always_comb
   begin
      irq_en_next = irq_en_reg;
      ctrl_next = ctrl_reg;
      if (reg_wr && reg_addr == `IEF_ADDR_IRQ_EN)
         irq_en_next = reg_wdata;
      if (reg_wr && reg_addr == `IEF_ADDR_CTRL)
         ctrl_next = reg_wdata;
      // A write to the error address falls through here
   end

   // Error flags: set wins over clear
   always_comb
   begin
      err_next = err_reg;
      coll_pos_next = coll_pos_reg;
      if (cmd_start && !ctrl_reg[`IEF_CTRL_MULTI])
         err_next[`IEF_BIT_WR_MISUSE] = 1'b0;
      if (errors_appended && ctrl_reg[`IEF_CTRL_MULTI])
         err_next[`IEF_BIT_WR_MISUSE] = 1'b0;
      if (rx_clear)
      begin
         err_next[`IEF_BIT_SHORT] = 1'b0;
         err_next[`IEF_BIT_COLL]  = 1'b0;
         err_next[`IEF_BIT_PROT]  = 1'b0;
         err_next[`IEF_BIT_INTEG] = 1'b0;
      end
      if (eeprom_cmd_done)
         err_next[`IEF_BIT_EE] = eeprom_cmd_fail;
      if (busy_wr)
         err_next[`IEF_BIT_WR_MISUSE] = 1'b1;
      if (fifo_wr && fifo_full)
         err_next[`IEF_BIT_OVERFLOW] = 1'b1;
      if (short_frame)
         err_next[`IEF_BIT_SHORT] = 1'b1;
      if (send_needed && fifo_empty)
         err_next[`IEF_BIT_EMPTY] = 1'b1;
      if (coll_hit)
      begin
         err_next[`IEF_BIT_COLL] = 1'b1;
         if (!err_reg[`IEF_BIT_COLL])
            coll_pos_next = {1'b1, collision_pos};
      end
      if (prot_hit)
         err_next[`IEF_BIT_PROT] = 1'b1;
      if (integ_hit)
         err_next[`IEF_BIT_INTEG] = 1'b1;
   end

   // Data path strobes and receive completion
   always_comb
   begin
      acc_next = fifo_wr && !fifo_full &&
         !err_reg[`IEF_BIT_OVERFLOW];
      store_next = byte_ready && !prot_hit;
      stop_next = prot_hit;
      drop_next = short_frame;
      rxdone_next = frame_end && !short_frame;
   end

   // Interrupt combination and pin drive
   always_comb
   begin
      erq_next = err_reg[`IEF_BIT_WR_MISUSE] |
         err_reg[`IEF_BIT_OVERFLOW] | err_reg[`IEF_BIT_PROT] |
         err_reg[`IEF_BIT_EMPTY] | err_reg[`IEF_BIT_INTEG];
      comb_next = |(timer_underflow_request &
         irq_en_reg[NUM_TIMERS-1:0]) ||
         (card_detect_request && irq_en_reg[`IEF_BIT_CARD_EN]);
      active = comb_next && irq_en_reg[`IEF_BIT_PIN_GATE];
      pin_next = active ^ ctrl_reg[`IEF_CTRL_INVERT];
      oe_next = irq_en_reg[`IEF_BIT_PUSH_PULL] || !pin_next;
   end

   // Read mux with one-cycle latency
   always_comb
   begin
      rdata_next = 8'h00;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `IEF_ADDR_IRQ_EN: rdata_next = irq_en_reg;
            `IEF_ADDR_ERROR:  rdata_next = err_reg;
            `IEF_ADDR_CTRL:   rdata_next = ctrl_reg;
            default:          rdata_next = 8'h00;
         endcase
      end
   end

   // State registers
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         irq_en_reg <= `IEF_IRQ_EN_RST;
         ctrl_reg <= `IEF_CTRL_RST;
         err_reg <= 8'h00;
         coll_pos_reg <= 8'h00;
         rdata_reg <= 8'h00;
         comb_reg <= 1'b0;
         erq_reg <= 1'b0;
         pin_reg <= 1'b0;
         oe_reg <= 1'b0;
         acc_reg <= 1'b0;
         store_reg <= 1'b0;
         stop_reg <= 1'b0;
         drop_reg <= 1'b0;
         rxdone_reg <= 1'b0;
      end
      else
      begin
         irq_en_reg <= irq_en_next;
         ctrl_reg <= ctrl_next;
         err_reg <= err_next;
         coll_pos_reg <= coll_pos_next;
         rdata_reg <= rdata_next;
         comb_reg <= comb_next;
         erq_reg <= erq_next;
         pin_reg <= pin_next;
         oe_reg <= oe_next;
         acc_reg <= acc_next;
         store_reg <= store_next;
         stop_reg <= stop_next;
         drop_reg <= drop_next;
         rxdone_reg <= rxdone_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign combined_interrupt_flag = comb_reg;
   assign error_request_flag = erq_reg;
   assign collision_position_register = coll_pos_reg;
   assign irq_pin_out = pin_reg;
   assign irq_pin_oe = oe_reg;
   assign fifo_wr_accept = acc_reg;
   assign rx_byte_store = store_reg;
   assign rx_stop = stop_reg;
   assign frame_drop = drop_reg;
   assign receive_done_request = rxdone_reg;

   // Checks on register access, pin drive and error flags
   property p_en_write;
      @(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == `IEF_ADDR_IRQ_EN
         |=> irq_en_reg == $past(reg_wdata);
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("enable write lost");
   property p_od;
      @(posedge sys_clk) disable iff (rst)
      !irq_en_reg[`IEF_BIT_PUSH_PULL] |=> !(irq_pin_oe && irq_pin_out);
   endproperty
   a_od: assert property (p_od)
      else $error("open drain drove high");
   property p_gate;
      @(posedge sys_clk) disable iff (rst)
      !irq_en_reg[`IEF_BIT_PIN_GATE]
         |=> irq_pin_out == $past(ctrl_reg[`IEF_CTRL_INVERT]);
   endproperty
   a_gate: assert property (p_gate)
      else $error("pin active while gated");
   property p_timer;
      @(posedge sys_clk) disable iff (rst)
      |(timer_underflow_request & irq_en_reg[NUM_TIMERS-1:0])
         |=> combined_interrupt_flag;
   endproperty
   a_timer: assert property (p_timer)
      else $error("timer request lost");
   property p_err_ro;
      @(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == `IEF_ADDR_ERROR && !busy_wr
      && !(fifo_wr && fifo_full) && !short_frame
      && !(send_needed && fifo_empty) && !coll_hit && !prot_hit
      && !integ_hit && !eeprom_cmd_done && !rx_clear && !cmd_start
      && !errors_appended |=> $stable(err_reg);
   endproperty
   a_err_ro: assert property (p_err_ro)
      else $error("error register written");
   property p_ovl;
      @(posedge sys_clk) disable iff (rst)
      err_reg[`IEF_BIT_OVERFLOW] && fifo_wr |=> !fifo_wr_accept;
   endproperty
   a_ovl: assert property (p_ovl)
      else $error("write after overflow");
   property p_prot_store;
      @(posedge sys_clk) disable iff (rst)
      prot_hit |=> !rx_byte_store && rx_stop && err_reg[`IEF_BIT_PROT];
   endproperty
   a_prot_store: assert property (p_prot_store)
      else $error("bad byte stored");
   property p_eof_coll;
      @(posedge sys_clk) disable iff (rst)
      collision && collision_in_eof && !err_reg[`IEF_BIT_COLL]
         |=> !err_reg[`IEF_BIT_COLL];
   endproperty
   a_eof_coll: assert property (p_eof_coll)
      else $error("end symbol collision flagged");
   property p_card;
      @(posedge sys_clk) disable iff (rst)
      card_detect_request && irq_en_reg[`IEF_BIT_CARD_EN]
         |=> combined_interrupt_flag;
   endproperty
   a_card: assert property (p_card)
      else $error("card request lost");
   property p_comb_off;
      @(posedge sys_clk) disable iff (rst)
      !(|(timer_underflow_request & irq_en_reg[NUM_TIMERS-1:0]))
      && !(card_detect_request && irq_en_reg[`IEF_BIT_CARD_EN])
         |=> !combined_interrupt_flag;
   endproperty
   a_comb_off: assert property (p_comb_off)
      else $error("masked request reached flag");
   property p_err_req;
      @(posedge sys_clk) disable iff (rst)
      err_reg[`IEF_BIT_WR_MISUSE] || err_reg[`IEF_BIT_OVERFLOW]
      || err_reg[`IEF_BIT_PROT] || err_reg[`IEF_BIT_EMPTY]
      || err_reg[`IEF_BIT_INTEG] |=> error_request_flag;
   endproperty
   a_err_req: assert property (p_err_req)
      else $error("error request missing");
   property p_misuse_set;
      @(posedge sys_clk) disable iff (rst)
      busy_wr |=> err_reg[`IEF_BIT_WR_MISUSE];
   endproperty
   a_misuse_set: assert property (p_misuse_set)
      else $error("misuse write not flagged");
   // Outside multi-frame mode a command start clears misuse
   sequence s_cmd_clear;
      cmd_start && !ctrl_reg[`IEF_CTRL_MULTI] && !busy_wr;
   endsequence
   property p_misuse_clear;
      @(posedge sys_clk) disable iff (rst)
      s_cmd_clear |=> !err_reg[`IEF_BIT_WR_MISUSE];
   endproperty
   a_misuse_clear: assert property (p_misuse_clear)
      else $error("misuse flag not cleared");
   // A short frame is dropped without a receive request
   sequence s_drop_result;
      frame_drop && !receive_done_request && err_reg[`IEF_BIT_SHORT];
   endsequence
   property p_short;
      @(posedge sys_clk) disable iff (rst)
      short_frame |=> s_drop_result;
   endproperty
   a_short: assert property (p_short)
      else $error("short frame not dropped");
   property p_coll_pos;
      @(posedge sys_clk) disable iff (rst)
      coll_hit && !err_reg[`IEF_BIT_COLL]
         |=> collision_position_register == {1'b1, $past(collision_pos)};
   endproperty
   a_coll_pos: assert property (p_coll_pos)
      else $error("collision position lost");
   property p_pin_on;
      @(posedge sys_clk) disable iff (rst)
      comb_next && irq_en_reg[`IEF_BIT_PIN_GATE]
         |=> irq_pin_out == !$past(ctrl_reg[`IEF_CTRL_INVERT]);
   endproperty
   a_pin_on: assert property (p_pin_on)
      else $error("pin request not shown");
endmodule : ief_irq_error

// File: verification/ief_host_model.sv
// Host model: register port master and interrupt pin observer.
// Assumes one sys_clk shared with the block; the pin has a pull-up.
module ief_host_model
(
   input  wire logic       sys_clk,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic       irq_pin_out,
   input  wire logic       irq_pin_oe,
   output wire logic       irq_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pin floats to the pull-up level
   assign irq_line = irq_pin_oe ? irq_pin_out : 1'b1;
   // Bus idle at time zero
   initial
   begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
   end
   // One-cycle access, held up to the sampling edge
   task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= wr;
      reg_rd <= !wr;
      @(posedge sys_clk);
      {reg_wr, reg_rd} <= 2'b00;
   endtask : bus
endmodule : ief_host_model

// File: verification/testbench.sv
// Self-checking bench for the interrupt enable and error flag block.
// Assumes the rtl files and the host model are compiled before it.
`include "ief_defines.svh"
module testbench
   import ief_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ENA = `IEF_ADDR_IRQ_EN;
   localparam logic [7:0] ERA = `IEF_ADDR_ERROR;
   localparam logic [7:0] CTL = `IEF_ADDR_CTRL;
   localparam int CMD = 0, RXS = 1, APP = 2, EED = 3, FWR = 4, SND = 5;
   localparam int FEND = 6, COL = 7, STB = 8, CNTB = 10, BYR = 11, PAR = 12;
   logic        sys_clk, rst, reg_wr, reg_rd, irq_pin_out, irq_pin_oe;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, collision_position_register;
   wire logic   irq_line;
   logic [5:0]  req, en;
   logic [13:0] ev;
   logic [2:0]  com_state;
   logic        crc_may_send, auth_active, transceive_cmd, eeprom_cmd_fail;
   logic        fifo_full, fifo_empty, sof_valid, collision_in_eof, lvl;
   logic [15:0] frame_bits;
   logic [6:0]  collision_pos;
   logic        fifo_wr_accept, rx_byte_store, rx_stop, frame_drop;
   logic        receive_done_request, error_request_flag;
   logic        combined_interrupt_flag, rd_seen;
   logic [7:0]  rnd;
   logic [7:0]  exp_q[$];
   int          miscompares, comparisons, cycles;
   ief_com_state_t st[3] = '{IEF_CS_RECEIVE_WAIT_STATE, IEF_CS_WAITDAT, IEF_CS_RX};

   ief_irq_error #(.NUM_TIMERS(5)) ief_irq_error_i
   (
      .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .timer_underflow_request(req[4:0]), .card_detect_request(req[5]),
      .com_state, .crc_may_send, .auth_active, .cmd_start(ev[CMD]),
      .receive_start(ev[RXS]), .transceive_cmd, .errors_appended(ev[APP]),
      .eeprom_cmd_done(ev[EED]), .eeprom_cmd_fail, .fifo_wr(ev[FWR]),
      .fifo_full, .send_needed(ev[SND]), .fifo_empty,
      .frame_end(ev[FEND]), .sof_valid, .frame_bits,
      .collision(ev[COL]), .collision_in_eof, .collision_pos,
      .stop_bit_bad(ev[STB]), .sof_eof_bad(ev[9]),
      .byte_count_bad(ev[CNTB]), .byte_ready(ev[BYR]),
      .parity_bad(ev[PAR]), .crc_bad(ev[13]), .fifo_wr_accept,
      .rx_byte_store, .rx_stop, .frame_drop, .receive_done_request,
      .error_request_flag, .combined_interrupt_flag,
      .collision_position_register, .irq_pin_out, .irq_pin_oe
   );
   ief_host_model ief_host_model_i
   (
      .sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .irq_pin_out,
      .irq_pin_oe, .irq_line
   );
   // Free-running core clock
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Read watcher takes the oldest note; cycle ceiling cuts hangs
   always @(posedge sys_clk)
   begin
      if (rd_seen)
         check(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         stop_test();
      end
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task stop_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task wr(input logic [7:0] a, input logic [7:0] d);
      ief_host_model_i.bus(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      ief_host_model_i.bus(1'b0, a, 8'h00);
      #1;
   endtask : rd
   // One-cycle event strobe, outputs settled on return
   task pulse(input int a, input int b = 99);
      @(posedge sys_clk);
      ev[a] <= 1'b1;
      if (b < 14)
         ev[b] <= 1'b1;
      @(posedge sys_clk);
      ev <= '0;
      #1;
   endtask : pulse
   task do_reset;
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
   endtask : do_reset
   task tdone(input string n);
      $display("test %s done", n);
   endtask : tdone
   // Main sequence
   initial
   begin
      {rst, req, ev, com_state, crc_may_send, auth_active} = '0;
      {transceive_cmd, eeprom_cmd_fail, fifo_full, fifo_empty} = '0;
      {sof_valid, collision_in_eof, frame_bits, collision_pos} = '0;
      {rd_seen, en, miscompares, comparisons, cycles} = '0;
      void'($urandom(32'h3c749c11));
      do_reset();
      check(irq_pin_oe, 1'b0);
      rd(ENA, `IEF_IRQ_EN_RST);
      rd(ERA, 8'h00);
      rd(8'h3C, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         rnd = 8'($urandom) ^ 8'(i);
         wr(ENA, rnd);
         rd(ENA, rnd);
      end
      wr(CTL, 8'h0B);
      rd(CTL, 8'h0B);
      wr(ERA, 8'hFF);
      rd(ERA, 8'h00);
      tdone("registers");
      for (int i = 0; i < 40; i++)
      begin
         en = (i < 6) ? 6'(1 << i) : ~6'(1 << (i % 6));
         if (i >= 12)
            en = 6'($urandom);
         wr(ENA, {2'b00, en});
         @(posedge sys_clk);
         req <= (i < 12) ? 6'(1 << (i % 6)) : 6'($urandom);
         repeat (2) @(posedge sys_clk);
         #1 check(combined_interrupt_flag, |(en & req));
      end
      tdone("gating");
      for (int k = 0; k < 16; k++)
      begin
         wr(CTL, {7'h00, k[2]});
         wr(ENA, {k[0], k[1], 6'h01});
         @(posedge sys_clk);
         req <= {5'h00, k[3]};
         repeat (3) @(posedge sys_clk);
         #1 lvl = (k[1] & k[3]) ^ k[2];
         check(irq_pin_out, lvl);
         check(irq_pin_oe, k[0] | !lvl);
         check(irq_line, lvl);
      end
      wr(CTL, 8'h00);
      tdone("pin");
      @(posedge sys_clk) eeprom_cmd_fail <= 1'b1;
      pulse(EED);
      rd(ERA, 8'h80);
      check(error_request_flag, 1'b0);
      @(posedge sys_clk) eeprom_cmd_fail <= 1'b0;
      pulse(EED);
      rd(ERA, 8'h00);
      pulse(FWR);
      check(fifo_wr_accept, 1'b1);
      for (int k = 0; k < 6; k++)
      begin
         @(posedge sys_clk) com_state <= (k < 3) ? st[k]
            : (k == 5) ? IEF_CS_RX : IEF_CS_IDLE;
         crc_may_send <= (k == 3);
         auth_active <= (k == 4);
         wr(CTL, (k == 5) ? 8'h04 : 8'h00);
         pulse(FWR);
         @(posedge sys_clk) {com_state, crc_may_send, auth_active} <= '0;
         rd(ERA, 8'h40);
         check(error_request_flag, 1'b1);
         pulse(CMD);
         rd(ERA, (k == 5) ? 8'h40 : 8'h00);
      end
      pulse(APP);
      rd(ERA, 8'h00);
      tdone("misuse");
      for (int j = 0; j < 4; j++)
      begin
         wr(CTL, (j > 1) ? 8'h08 : 8'h00);
         @(posedge sys_clk) sof_valid <= 1'b1;
         frame_bits <= (j > 1) ? 16'(23 + j % 2) : 16'(3 + j % 2);
         pulse(FEND);
         check(frame_drop, !j[0]);
         check(receive_done_request, j[0]);
      end
      rd(ERA, 8'h10);
      wr(CTL, 8'h00);
      for (int i = STB; i <= CNTB; i++)
      begin
         pulse(RXS);
         pulse(i, BYR);
         check(rx_stop, 1'b1);
         check(rx_byte_store, 1'b0);
         rd(ERA, 8'h02);
      end
      pulse(BYR);
      check(rx_byte_store, 1'b1);
      for (int i = PAR; i <= 13; i++)
      begin
         pulse(RXS);
         pulse(i);
         check(rx_stop, 1'b0);
         rd(ERA, 8'h01);
      end
      pulse(RXS);
      @(posedge sys_clk) collision_pos <= 7'h05;
      pulse(COL);
      @(posedge sys_clk) collision_pos <= 7'h09;
      pulse(COL);
      check(collision_position_register, 8'h85);
      rd(ERA, 8'h04);
      pulse(RXS);
      @(posedge sys_clk) collision_in_eof <= 1'b1;
      pulse(COL);
      rd(ERA, 8'h00);
      @(posedge sys_clk) collision_in_eof <= 1'b0;
      wr(CTL, 8'h02);
      pulse(COL);
      rd(ERA, 8'h05);
      @(posedge sys_clk) transceive_cmd <= 1'b1;
      pulse(RXS);
      rd(ERA, 8'h05);
      @(posedge sys_clk) com_state <= IEF_CS_WAITDAT;
      @(posedge sys_clk) com_state <= IEF_CS_IDLE;
      rd(ERA, 8'h00);
      tdone("receive");
      @(posedge sys_clk) fifo_empty <= 1'b1;
      pulse(SND);
      rd(ERA, 8'h08);
      check(error_request_flag, 1'b1);
      @(posedge sys_clk);
      do_reset();
      check(irq_pin_oe, 1'b0);
      check(combined_interrupt_flag, 1'b0);
      rd(ERA, 8'h00);
      @(posedge sys_clk) fifo_full <= 1'b1;
      pulse(FWR);
      check(fifo_wr_accept, 1'b0);
      @(posedge sys_clk) fifo_full <= 1'b0;
      pulse(FWR);
      check(fifo_wr_accept, 1'b0);
      rd(ERA, 8'h20);
      check(error_request_flag, 1'b1);
      tdone("fifo");
      repeat (3) @(posedge sys_clk);
      stop_test();
   end
endmodule : testbench
